// ===== src/lps_persist.sv
`timescale 1ns/100ps
module lps_persist (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       evt,
  input  wire logic       hit,
  input  wire logic [1:0] sel,
  output logic            fire
);
  import lps_pkg::*;

  typedef struct packed {
    logic [4:0] cnt;
    logic       fire;
  } lps_persist_st_t;

  lps_persist_st_t s;
  lps_persist_st_t next_s;
  logic [4:0]      need;

  // count saturates at the target so each further hit fires again
  always_comb begin
    next_s = s;
    next_s.fire = 1'b0;
    case (sel)
      2'h0: need = PERSIST_0;
      2'h1: need = PERSIST_1;
      2'h2: need = PERSIST_2;
      default: need = PERSIST_3;
    endcase
    if (evt) begin
      if (!hit) begin
        next_s.cnt = '0;
      end else begin
        if (s.cnt < need) begin
          next_s.cnt = s.cnt + 5'h01;
        end
        next_s.fire = (next_s.cnt >= need);
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign fire = s.fire;
endmodule

// ===== src/lps_pkg.sv
package lps_pkg;
  // timing figures and the clock they are counted in
  localparam int unsigned CLK_MHZ       = 100;
  localparam int unsigned LIGHT_CONV_US = 100000;
  localparam int unsigned NEAR_CONV_US  = 540;
  localparam int unsigned LED_PULSE_US  = 100;
  localparam int unsigned SLEEP_STEP_US = 100000;
  localparam int unsigned POWERUP_US    = 1000;

  // serial port
  localparam logic [6:0] DEV_ADDR  = 7'h44;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // register addresses
  localparam logic [7:0] REG_ID       = 8'h00;
  localparam logic [7:0] REG_CFG      = 8'h01;
  localparam logic [7:0] REG_IRQ      = 8'h02;
  localparam logic [7:0] REG_NLT      = 8'h03;
  localparam logic [7:0] REG_NHT      = 8'h04;
  localparam logic [7:0] REG_LTH1     = 8'h05;
  localparam logic [7:0] REG_LTH2     = 8'h06;
  localparam logic [7:0] REG_LTH3     = 8'h07;
  localparam logic [7:0] REG_NDATA    = 8'h08;
  localparam logic [7:0] REG_LDATA_LO = 8'h09;
  localparam logic [7:0] REG_LDATA_HI = 8'h0a;

  // reset values of the writable registers
  localparam logic [7:0] CFG_RST  = 8'h00;
  localparam logic [7:0] IRQ_RST  = 8'h00;
  localparam logic [7:0] NLT_RST  = 8'h00;
  localparam logic [7:0] NHT_RST  = 8'hff;
  localparam logic [7:0] LTH1_RST = 8'h00;
  localparam logic [7:0] LTH2_RST = 8'hf0;
  localparam logic [7:0] LTH3_RST = 8'hff;

  // field positions
  localparam int CFG_NEAR_EN  = 7;
  localparam int CFG_SLP_HI   = 6;
  localparam int CFG_SLP_LO   = 4;
  localparam int CFG_DRIVE    = 3;
  localparam int CFG_LIGHT_EN = 2;
  localparam int CFG_SEL      = 0;
  localparam int IRQ_NFLAG    = 7;
  localparam int IRQ_NP_HI    = 6;
  localparam int IRQ_NP_LO    = 5;
  localparam int IRQ_W0       = 4;
  localparam int IRQ_LFLAG    = 3;
  localparam int IRQ_LP_HI    = 2;
  localparam int IRQ_LP_LO    = 1;
  localparam int IRQ_AND      = 0;

  // persistency field to count of consecutive triggers
  localparam logic [4:0] PERSIST_0 = 5'h01;
  localparam logic [4:0] PERSIST_1 = 5'h04;
  localparam logic [4:0] PERSIST_2 = 5'h08;
  localparam logic [4:0] PERSIST_3 = 5'h10;

  typedef enum logic [3:0] {
    I_IDLE, I_ADDR, I_AACK, I_REG, I_PACK, I_WDATA, I_WACK, I_RDATA, I_RACK
  } lps_i2c_st_t;

  typedef enum logic [1:0] {N_OFF, N_LED, N_CONV, N_SLEEP} lps_near_st_t;

  // converter levels as presented by the analog front end
  typedef struct packed {
    logic [11:0] light_vis;
    logic [11:0] light_ir;
    logic [7:0]  ir_return;
  } lps_sense_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } lps_bus_t;
endpackage

// ===== src/lps_sync.sv
`timescale 1ns/100ps
module lps_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } lps_sync_st_t;

  lps_sync_st_t s;
  lps_sync_st_t next_s;

  // first stage feeds only the second
  always_comb begin
    next_s.s1 = d;
    next_s.s2 = s.s1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign q = s.s2;
endmodule

// ===== src/lps_top.sv
`timescale 1ns/100ps
// How it works
// - 12-bit light result every 100ms in 0x9/0xA
// - 8-bit near result stored at 0x8
// - near result is LED-on minus LED-off reading
// - light conversion free-runs every 100ms while enabled
// - near conversions repeat, sleep set by field
// - data registers change only after whole conversion
// - channel select picks visible or infrared light
// - LED driver pulses 0.1ms per near conversion
// - drive bit selects 110mA or 220mA pulse
// - near conversion lasts 0.54ms before sleeping
// - light flag set outside threshold window
// - light flag holds until host writes 0
// - near flag set above high threshold
// - near flag cleared below low or by host
// - independent persistency per channel before pin
// - combine bit selects AND or OR
// - both enables clear means power-down
// - slave only, bytes shifted MSB first
// - ignore bus until START, none during power-up
// - STOP returns serial logic to idle
// - early STOP aborts access, registers unchanged
// - slave address 1000100, then read/write bit
// - acknowledge address, pointer and write data
// - pointer increments per byte, rolls over
module lps_top #(
  parameter int unsigned LIGHT_CYC   = lps_pkg::LIGHT_CONV_US * lps_pkg::CLK_MHZ,
  parameter int unsigned NEAR_CYC    = lps_pkg::NEAR_CONV_US * lps_pkg::CLK_MHZ,
  parameter int unsigned LED_CYC     = lps_pkg::LED_PULSE_US * lps_pkg::CLK_MHZ,
  parameter int unsigned SLEEP_CYC   = lps_pkg::SLEEP_STEP_US * lps_pkg::CLK_MHZ,
  parameter int unsigned POWERUP_CYC = lps_pkg::POWERUP_US * lps_pkg::CLK_MHZ,
  parameter logic [7:0]  CHIP_ID     = 8'h5a  // arbitrary value
) (
  input  wire logic               ref_clk,
  input  wire logic               rst,
  input  wire logic               scl,
  input  wire logic               sda_in,
  output logic                    sda_out,
  output logic                    sda_oe_n,
  input  wire lps_pkg::lps_sense_t sense,
  output logic                    led_driver_output,
  output logic                    led_drive_strength,
  output logic                    int_n,
  output logic                    power_down
);
  import lps_pkg::*;

  localparam logic [31:0] L_END  = 32'(LIGHT_CYC - 1);
  localparam logic [31:0] LED_END = 32'(LED_CYC - 1);
  localparam logic [31:0] C_END  = 32'(NEAR_CYC - LED_CYC - 1);
  localparam logic [31:0] PU_INIT = 32'(POWERUP_CYC);

  typedef struct packed {
    lps_i2c_st_t  ist;
    logic [3:0]   bitn;
    logic [7:0]   shreg;
    logic [7:0]   ptr;
    logic         rnw;
    logic         mack;
    logic         scl_d;
    logic         sda_d;
    logic         sda_oe_n;
    logic         sda_lvl;
    logic [7:0][7:0] regs;
    logic [7:0]   near_data;
    logic [11:0]  light_data;
    logic [31:0]  lcnt;
    lps_near_st_t nst;
    logic [31:0]  ncnt;
    logic [7:0]   ir_off;
    logic         ldone;
    logic         ndone;
    logic [31:0]  pu_cnt;
    logic         led;
    logic         int_n;
    logic         pdn;
  } lps_top_st_t;

  localparam lps_top_st_t TOP_RST = '{
    ist: I_IDLE, bitn: 4'h0, shreg: 8'h00, ptr: REG_ID, rnw: 1'b0,
    mack: 1'b0, scl_d: 1'b1, sda_d: 1'b1, sda_oe_n: 1'b1, sda_lvl: 1'b0,
    regs: {LTH3_RST, LTH2_RST, LTH1_RST, NHT_RST, NLT_RST, IRQ_RST,
           CFG_RST, CHIP_ID},
    near_data: 8'h00, light_data: 12'h000, lcnt: 32'h0, nst: N_OFF,
    ncnt: 32'h0, ir_off: 8'h00, ldone: 1'b0, ndone: 1'b0,
    pu_cnt: PU_INIT, led: 1'b0, int_n: 1'b1, pdn: 1'b1
  };

  lps_top_st_t s;
  lps_top_st_t next_s;
  lps_bus_t    bus;
  lps_sense_t  lvl;
  logic        start;
  logic        stop;
  logic        scl_rise;
  logic        scl_fall;
  logic [7:0]  ptr_inc;
  logic        light_en;
  logic        near_en;
  logic [11:0] light_lo;
  logic [11:0] light_hi;
  logic        light_fire;
  logic        near_hi_fire;
  logic        near_lo_fire;
  logic [31:0] slp_end;

  // pins come from outside the clock domain
  lps_sync #(
    .W ($bits(lps_bus_t))
  ) u_bus_sync (
    .clk (ref_clk),
    .rst (rst),
    .d   ({scl, sda_in}),
    .q   (bus)
  );

  // levels are sampled only at conversion boundaries, long after settling
  lps_sync #(
    .W ($bits(lps_sense_t))
  ) u_sense_sync (
    .clk (ref_clk),
    .rst (rst),
    .d   (sense),
    .q   (lvl)
  );

  lps_persist u_light_persist (
    .clk  (ref_clk),
    .rst  (rst),
    .evt  (s.ldone),
    .hit  ((s.light_data < light_lo) || (s.light_data > light_hi)),
    .sel  (s.regs[REG_IRQ[2:0]][IRQ_LP_HI:IRQ_LP_LO]),
    .fire (light_fire)
  );

  lps_persist u_near_hi_persist (
    .clk  (ref_clk),
    .rst  (rst),
    .evt  (s.ndone),
    .hit  (s.near_data > s.regs[REG_NHT[2:0]]),
    .sel  (s.regs[REG_IRQ[2:0]][IRQ_NP_HI:IRQ_NP_LO]),
    .fire (near_hi_fire)
  );

  lps_persist u_near_lo_persist (
    .clk  (ref_clk),
    .rst  (rst),
    .evt  (s.ndone),
    .hit  (s.near_data < s.regs[REG_NLT[2:0]]),
    .sel  (s.regs[REG_IRQ[2:0]][IRQ_NP_HI:IRQ_NP_LO]),
    .fire (near_lo_fire)
  );

  // bus conditions from the synchronised lines
  assign scl_rise = bus.scl & ~s.scl_d;
  assign scl_fall = ~bus.scl & s.scl_d;
  assign start    = bus.scl & s.scl_d & s.sda_d & ~bus.sda;
  assign stop     = bus.scl & s.scl_d & ~s.sda_d & bus.sda;
  assign ptr_inc  = (s.ptr >= REG_LDATA_HI) ? REG_ID : s.ptr + 8'h01;

  // configuration fields
  assign light_en = s.regs[REG_CFG[2:0]][CFG_LIGHT_EN];
  assign near_en  = s.regs[REG_CFG[2:0]][CFG_NEAR_EN];
  assign light_lo = {s.regs[REG_LTH2[2:0]][3:0], s.regs[REG_LTH1[2:0]]};
  assign light_hi = {s.regs[REG_LTH3[2:0]], s.regs[REG_LTH2[2:0]][7:4]};
  assign slp_end  = SLEEP_CYC * {29'h0, s.regs[REG_CFG[2:0]][CFG_SLP_HI:CFG_SLP_LO]};

  // read mux; holes above the map read as zero
  function automatic logic [7:0] rd_byte(input lps_top_st_t st, input logic [7:0] a);
    logic [7:0] r;
    r = 8'h00;
    if (a <= REG_LTH3) begin
      r = st.regs[a[2:0]];
    end else if (a == REG_NDATA) begin
      r = st.near_data;
    end else if (a == REG_LDATA_LO) begin
      r = st.light_data[7:0];
    end else if (a == REG_LDATA_HI) begin
      r = {4'h0, st.light_data[11:8]};
    end
    return r;
  endfunction

  always_comb begin
    next_s = s;
    next_s.ldone = 1'b0;
    next_s.ndone = 1'b0;
    next_s.sda_lvl = 1'b0;
    next_s.scl_d = bus.scl;
    next_s.sda_d = bus.sda;
    if (s.pu_cnt != 32'h0) begin
      next_s.pu_cnt = s.pu_cnt - 32'h1;
    end

    // serial slave: sample on scl rise, change sda on scl fall
    if (stop) begin
      next_s.ist = I_IDLE;
      next_s.sda_oe_n = 1'b1;
    end else if (start && s.pu_cnt == 32'h0) begin
      next_s.ist = I_ADDR;
      next_s.bitn = 4'h0;
      next_s.sda_oe_n = 1'b1;
    end else if (scl_rise) begin
      case (s.ist)
        I_ADDR, I_REG, I_WDATA: begin
          next_s.bitn = s.bitn + 4'h1;
          next_s.shreg = {s.shreg[6:0], bus.sda};
        end
        I_RDATA: begin
          next_s.bitn = s.bitn + 4'h1;
        end
        I_RACK: begin
          next_s.mack = ~bus.sda;
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (s.ist)
        I_ADDR: begin
          if (s.bitn == BYTE_BITS) begin
            if (s.shreg[7:1] == DEV_ADDR) begin
              next_s.ist = I_AACK;
              next_s.rnw = s.shreg[0];
              next_s.sda_oe_n = 1'b0;
            end else begin
              next_s.ist = I_IDLE;
            end
          end
        end
        I_AACK: begin
          next_s.bitn = 4'h0;
          if (s.rnw) begin
            next_s.ist = I_RDATA;
            next_s.shreg = rd_byte(s, s.ptr);
            next_s.sda_oe_n = next_s.shreg[7];
          end else begin
            next_s.ist = I_REG;
            next_s.sda_oe_n = 1'b1;
          end
        end
        I_REG: begin
          if (s.bitn == BYTE_BITS) begin
            next_s.ptr = s.shreg;
            next_s.ist = I_PACK;
            next_s.sda_oe_n = 1'b0;
          end
        end
        I_PACK: begin
          next_s.ist = I_WDATA;
          next_s.bitn = 4'h0;
          next_s.sda_oe_n = 1'b1;
        end
        I_WDATA: begin
          if (s.bitn == BYTE_BITS) begin
            next_s.ist = I_WACK;
            next_s.sda_oe_n = 1'b0;
          end
        end
        I_WACK: begin
          // commit only once byte and acknowledge are complete
          if (s.ptr == REG_IRQ) begin
            next_s.regs[REG_IRQ[2:0]] = s.shreg;
            next_s.regs[REG_IRQ[2:0]][IRQ_W0] = 1'b0;
            next_s.regs[REG_IRQ[2:0]][IRQ_NFLAG] =
              s.regs[REG_IRQ[2:0]][IRQ_NFLAG] & s.shreg[IRQ_NFLAG];
            next_s.regs[REG_IRQ[2:0]][IRQ_LFLAG] =
              s.regs[REG_IRQ[2:0]][IRQ_LFLAG] & s.shreg[IRQ_LFLAG];
          end else if (s.ptr >= REG_CFG && s.ptr <= REG_LTH3) begin
            next_s.regs[s.ptr[2:0]] = s.shreg;
          end
          next_s.ptr = ptr_inc;
          next_s.ist = I_WDATA;
          next_s.bitn = 4'h0;
          next_s.sda_oe_n = 1'b1;
        end
        I_RDATA: begin
          if (s.bitn == BYTE_BITS) begin
            next_s.ist = I_RACK;
            next_s.sda_oe_n = 1'b1;
            next_s.ptr = ptr_inc;
          end else begin
            next_s.shreg = {s.shreg[6:0], 1'b0};
            next_s.sda_oe_n = next_s.shreg[7];
          end
        end
        I_RACK: begin
          if (s.mack) begin
            next_s.ist = I_RDATA;
            next_s.bitn = 4'h0;
            next_s.shreg = rd_byte(s, s.ptr);
            next_s.sda_oe_n = next_s.shreg[7];
          end else begin
            next_s.ist = I_IDLE;
          end
        end
        default: begin
          next_s.sda_oe_n = 1'b1;
        end
      endcase
    end

    // light converter free-runs; result lands only at the end
    if (light_en) begin
      if (s.lcnt == L_END) begin
        next_s.lcnt = 32'h0;
        next_s.ldone = 1'b1;
        if (s.regs[REG_CFG[2:0]][CFG_SEL]) begin
          next_s.light_data = lvl.light_ir;
        end else begin
          next_s.light_data = lvl.light_vis;
        end
      end else begin
        next_s.lcnt = s.lcnt + 32'h1;
      end
    end else begin
      next_s.lcnt = 32'h0;
    end

    // near converter: off reading, LED pulse, finish, sleep
    case (s.nst)
      N_OFF: begin
        next_s.led = 1'b0;
        next_s.ncnt = 32'h0;
        if (near_en) begin
          next_s.ir_off = lvl.ir_return;
          next_s.led = 1'b1;
          next_s.nst = N_LED;
        end
      end
      N_LED: begin
        next_s.ncnt = s.ncnt + 32'h1;
        if (s.ncnt == LED_END) begin
          next_s.led = 1'b0;
          next_s.ncnt = 32'h0;
          next_s.nst = N_CONV;
          // on reading less off reading, floored at zero
          next_s.ir_off = (lvl.ir_return > s.ir_off) ?
                          lvl.ir_return - s.ir_off : 8'h00;
        end
      end
      N_CONV: begin
        next_s.ncnt = s.ncnt + 32'h1;
        if (s.ncnt == C_END) begin
          next_s.near_data = s.ir_off;
          next_s.ndone = 1'b1;
          next_s.ncnt = 32'h0;
          next_s.nst = N_SLEEP;
        end
      end
      N_SLEEP: begin
        next_s.ncnt = s.ncnt + 32'h1;
        if (s.ncnt >= slp_end) begin
          next_s.ncnt = 32'h0;
          next_s.ir_off = lvl.ir_return;
          next_s.led = 1'b1;
          next_s.nst = N_LED;
        end
      end
      default: begin
        next_s.nst = N_OFF;
      end
    endcase
    if (!near_en) begin
      next_s.nst = N_OFF;
      next_s.led = 1'b0;
    end

    // flag updates after host writes, so a set wins over a clear
    if (light_fire) begin
      next_s.regs[REG_IRQ[2:0]][IRQ_LFLAG] = 1'b1;
    end
    if (near_lo_fire) begin
      next_s.regs[REG_IRQ[2:0]][IRQ_NFLAG] = 1'b0;
    end
    if (near_hi_fire) begin
      next_s.regs[REG_IRQ[2:0]][IRQ_NFLAG] = 1'b1;
    end

    // pin follows the flags with one register of delay
    if (s.regs[REG_IRQ[2:0]][IRQ_AND]) begin
      next_s.int_n = ~(s.regs[REG_IRQ[2:0]][IRQ_LFLAG] &
                       s.regs[REG_IRQ[2:0]][IRQ_NFLAG]);
    end else begin
      next_s.int_n = ~(s.regs[REG_IRQ[2:0]][IRQ_LFLAG] |
                       s.regs[REG_IRQ[2:0]][IRQ_NFLAG]);
    end
    next_s.pdn = ~light_en & ~near_en;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s <= TOP_RST;
    end else begin
      s <= next_s;
    end
  end

  // all outputs straight from state flops
  assign sda_out            = s.sda_lvl;
  assign sda_oe_n           = s.sda_oe_n;
  assign led_driver_output  = s.led;
  assign led_drive_strength = s.regs[REG_CFG[2:0]][CFG_DRIVE];
  assign int_n              = s.int_n;
  assign power_down         = s.pdn;
endmodule

// ===== test/lps_host_model.sv
`timescale 1ns/100ps
module lps_host_model (
  output logic      scl,
  output logic      sda_m,
  input  wire logic sda_w
);
  localparam realtime Q = 31.25;

  // bus idle: both lines released to the pull-ups
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  // one bit: data set mid-low, sampled mid-high, ends with scl low
  task automatic clk_bit(input logic b, output logic r);
    #Q sda_m = b;
    #Q scl = 1'b1;
    #Q r = sda_w;
    #Q scl = 1'b0;
  endtask
  // sda raised with scl low first, so a repeated start gets a clean fall
  task automatic start();
    #Q sda_m = 1'b1;
    #Q scl = 1'b1;
    #Q sda_m = 1'b0;
    #Q scl = 1'b0;
  endtask
  task automatic stop();
    #Q sda_m = 1'b0;
    #Q scl = 1'b1;
    #Q sda_m = 1'b1;
    #Q;
  endtask
  // bytes go out most significant bit first, ninth bit left to the slave
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], r);
    clk_bit(1'b1, r);
    ack = ~r;
  endtask
  // more = 0 gives the closing nack
  task automatic rbyte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
    clk_bit(~more, r);
  endtask
endmodule

// ===== test/lps_top_properties.sv
`timescale 1ns/100ps
module lps_top_properties #(
  parameter int unsigned LED_CYC     = 10,
  parameter int unsigned NEAR_CYC    = 60,
  parameter int unsigned POWERUP_CYC = 50
) (
  input wire logic                ref_clk,
  input wire logic                rst,
  input wire logic                scl,
  input wire logic                sda_in,
  input wire logic                sda_out,
  input wire logic                sda_oe_n,
  input wire lps_pkg::lps_sense_t sense,
  input wire logic                led_driver_output,
  input wire logic                led_drive_strength,
  input wire logic                int_n,
  input wire logic                power_down
);
  import lps_pkg::*;
  logic [31:0] hi_cnt;
  logic [31:0] lo_cnt;
  logic [31:0] pu_cnt;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  // pulse high/low run lengths and age since reset; low count starts saturated
  // so the first pulse after reset is not judged against a gap it never had
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hi_cnt <= '0;
      lo_cnt <= 32'h0000ffff;
      pu_cnt <= '0;
    end else begin
      hi_cnt <= led_driver_output ? hi_cnt + 32'h1 : '0;
      lo_cnt <= led_driver_output ? '0 : lo_cnt + {31'h0, lo_cnt < 32'h0000ffff};
      pu_cnt <= pu_cnt + {31'h0, pu_cnt < POWERUP_CYC};
    end
  end

  property p_open_drain; !sda_oe_n |-> sda_out == 1'b0; endproperty
  a_open_drain: assert property (p_open_drain) else $error("sda driven high");
  property p_quiet_pu; (pu_cnt < POWERUP_CYC) |-> sda_oe_n; endproperty
  a_quiet_pu: assert property (p_quiet_pu) else $error("sda driven in power-up");
  property p_sda_scl_low; $changed(sda_oe_n) |-> !scl && !$past(scl); endproperty
  a_sda_scl_low: assert property (p_sda_scl_low) else $error("sda moved, scl high");
  property p_led_width; $fell(led_driver_output) |-> hi_cnt == LED_CYC; endproperty
  a_led_width: assert property (p_led_width) else $error("led pulse width");
  property p_led_gap; $rose(led_driver_output) |-> lo_cnt >= NEAR_CYC - LED_CYC; endproperty
  a_led_gap: assert property (p_led_gap) else $error("led pulses too close");
  property p_pd_dark; power_down ##1 power_down |-> !led_driver_output; endproperty
  a_pd_dark: assert property (p_pd_dark) else $error("led on in power-down");
  property p_pd_rise; $rose(led_driver_output) |-> !power_down; endproperty
  a_pd_rise: assert property (p_pd_rise) else $error("pulse while powered down");
  property p_reset_out;
    $fell(rst) |-> int_n && power_down && sda_oe_n && !led_driver_output;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("outputs after reset");

  c_start: cover property (scl && $fell(sda_in));
  c_strong: cover property ($rose(led_driver_output) && led_drive_strength);
  c_ack: cover property ($fell(sda_oe_n));
  c_irq: cover property ($fell(int_n));
endmodule

bind lps_top lps_top_properties #(
  .LED_CYC(LED_CYC), .NEAR_CYC(NEAR_CYC), .POWERUP_CYC(POWERUP_CYC)
) u_props (
  .ref_clk(ref_clk), .rst(rst), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe_n(sda_oe_n), .sense(sense), .led_driver_output(led_driver_output),
  .led_drive_strength(led_drive_strength), .int_n(int_n), .power_down(power_down)
);

// ===== test/lps_top_tb_top.sv
`timescale 1ns/100ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module lps_top_tb_top;
  import lps_pkg::*;
  localparam int unsigned LC = 200;
  localparam int unsigned NC = 60;
  localparam int unsigned EC = 10;
  localparam int unsigned SC = 20;
  localparam int unsigned PC = 50;
  localparam logic [7:0]  ID = 8'h3c; // arbitrary value
  logic       ref_clk;
  logic       rst;
  logic       scl;
  logic       sda_m;
  logic       sda_out;
  logic       sda_oe_n;
  logic       led;
  logic       drv;
  logic       int_n;
  logic       pd;
  logic [11:0] vis;
  logic [11:0] irl;
  logic [7:0] echo;
  logic [7:0] ir_r;
  lps_sense_t sense;
  int         n_fail;
  int         num_checks;
  wire        sda_w = sda_m & sda_oe_n; // pull-up, open drain

  // reflected level follows the led, updated off the sampling edge
  always @(negedge ref_clk) ir_r <= led ? echo : 8'h10;
  assign sense = {vis, irl, ir_r};
  always #5 ref_clk = ~ref_clk;

  lps_top #(.LIGHT_CYC(LC), .NEAR_CYC(NC), .LED_CYC(EC), .SLEEP_CYC(SC), .POWERUP_CYC(PC),
    .CHIP_ID(ID)) dut (.ref_clk(ref_clk), .rst(rst), .scl(scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .sense(sense), .led_driver_output(led),
    .led_drive_strength(drv), .int_n(int_n), .power_down(pd));
  lps_host_model m (.scl(scl), .sda_m(sda_m), .sda_w(sda_w));

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic do_reset();
    cyc(1);
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    logic k1, k2, k3;
    m.start();
    m.wbyte({DEV_ADDR, 1'b0}, k1);
    m.wbyte(a, k2);
    m.wbyte(d, k3);
    m.stop();
    `CHK({k1, k2, k3}, 3'b111)
  endtask
  // burst read from a, one expected byte per entry
  task automatic chk_regs(input logic [7:0] a, input logic [7:0] e [$]);
    logic [7:0] d;
    logic k1, k2, k3;
    m.start();
    m.wbyte({DEV_ADDR, 1'b0}, k1);
    m.wbyte(a, k2);
    m.start();
    m.wbyte({DEV_ADDR, 1'b1}, k3);
    `CHK({k1, k2, k3}, 3'b111)
    foreach (e[i]) begin
      m.rbyte(i < e.size() - 1, d);
      `CHK(d, e[i])
    end
    m.stop();
  endtask
  // cycles until the next led rise, capped so a dead led cannot hang
  task automatic led_rise(output int n);
    n = 0;
    while (led !== 1'b0 && n < 999) begin
      cyc(1);
      n++;
    end
    while (led !== 1'b1 && n < 999) begin
      cyc(1);
      n++;
    end
  endtask

  task automatic t_powerup();
    logic k;
    logic [15:0] rw [4] = '{16'h0100, 16'h0f29, 16'h0e00, 16'h0f00};
    // reset has stood since time zero; two edges then release
    cyc(2);
    rst = 1'b0;
    `CHK({int_n, pd, drv, led, sda_oe_n}, 5'b11001)
    m.start();
    m.wbyte({DEV_ADDR, 1'b0}, k);
    m.stop();
    `CHK(k, 1'b0)
    cyc(PC);
    foreach (rw[i]) wr_reg(rw[i][15:8], rw[i][7:0]);
    cyc(PC);
    chk_regs(REG_CFG, {CFG_RST, IRQ_RST, NLT_RST, NHT_RST, LTH1_RST, LTH2_RST, LTH3_RST});
    chk_regs(REG_LDATA_HI, {8'h00, ID});
  endtask
  // stop in mid data byte must leave the register alone
  task automatic t_abort();
    logic k;
    m.start();
    m.wbyte({DEV_ADDR, 1'b0}, k);
    m.wbyte(REG_NLT, k);
    repeat (4) m.clk_bit(1'b1, k);
    m.stop();
    chk_regs(REG_NLT, {NLT_RST});
    wr_reg(REG_NLT, 8'h5c);
    chk_regs(REG_NLT, {8'h5c});
  endtask
  task automatic t_near();
    int p;
    do_reset();
    cyc(PC + 5);
    echo = 8'h50;
    wr_reg(REG_CFG, 8'h88);
    cyc(2);
    `CHK(drv, 1'b1)
    cyc(2 * NC);
    chk_regs(REG_NDATA, {8'h40});
    wr_reg(REG_IRQ, 8'h60); // near persist of 16 hits
    wr_reg(REG_NHT, 8'h30);
    cyc(10 * NC);
    `CHK(int_n, 1'b1)
    cyc(8 * NC);
    `CHK(int_n, 1'b0)
    echo = 8'h08;
    wr_reg(REG_NLT, 8'h20);
    cyc(18 * NC);
    `CHK(int_n, 1'b1)
    chk_regs(REG_NDATA, {8'h00});
    wr_reg(REG_CFG, 8'h98);
    led_rise(p);
    led_rise(p);
    `CHK(p >= NC + SC && p <= NC + SC + 3, 1'b1)
  endtask
  task automatic t_light();
    do_reset();
    cyc(PC + 5);
    vis = 12'h5a3;
    irl = 12'h1c7;
    wr_reg(REG_CFG, 8'h04);
    `CHK(pd, 1'b0)
    cyc(LC + 20);
    chk_regs(REG_LDATA_LO, {8'ha3, 8'h05});
    wr_reg(REG_CFG, 8'h05);
    cyc(2 * LC);
    chk_regs(REG_LDATA_LO, {8'hc7, 8'h01});
    wr_reg(REG_CFG, 8'h00);
    cyc(3);
    `CHK(pd, 1'b1)
  endtask
  // light persist of 4, window pulled below the reading
  task automatic t_irq();
    do_reset();
    cyc(PC + 5);
    wr_reg(REG_CFG, 8'h04);
    wr_reg(REG_IRQ, 8'h02);
    wr_reg(REG_LTH3, 8'h10);
    cyc(3 * LC - 30);
    `CHK(int_n, 1'b1)
    cyc(LC + 40);
    `CHK(int_n, 1'b0)
    wr_reg(REG_IRQ, 8'h0b);
    cyc(3);
    `CHK(int_n, 1'b1)
    wr_reg(REG_IRQ, 8'h0a);
    wr_reg(REG_LTH3, 8'hff);
    cyc(2 * LC);
    `CHK(int_n, 1'b0)
    wr_reg(REG_IRQ, 8'h02);
    cyc(3);
    `CHK(int_n, 1'b1)
  endtask

  task automatic wrap_up();
    if (n_fail == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    ref_clk = 1'b0;
    rst = 1'b1;
    vis = 12'h000;
    irl = 12'h000;
    echo = 8'h00;
    ir_r = 8'h10;
    n_fail = 0;
    num_checks = 0;
    t_powerup();
    t_abort();
    t_near();
    t_light();
    t_irq();
    wrap_up();
  end
  // hang guard, well past the expected run length
  initial begin
    #800000;
    n_fail++;
    wrap_up();
  end
endmodule
